// File: logic/lssld_pkg.sv
/*
  Constants shared by the LED sink shift/latch/detect control logic:
  channel count, mode-sequence patterns and recogniser limits.
  Assumes nothing of its surroundings; imported by the core module.
*/
`default_nettype none

package lssld_pkg;
  // ---------------------------------------------------------------
  // channel and pattern geometry
  // ---------------------------------------------------------------
  localparam int CHAN_NUM = 16;
  localparam int SEQ_LEN = 5;
  localparam int SYNC_DEPTH = 2;
  // blank level expected on steps 1..5, bit 0 = step 1
  localparam logic [4:0] SEQ_BLANK = 5'h1D;
  // strobe level for the detect-entry pattern (high on step 4 only)
  localparam logic [4:0] SEQ_ENTER_STROBE = 5'h08;
  // strobe level for the resume pattern (low throughout)
  localparam logic [4:0] SEQ_RESUME_STROBE = 5'h00;
  // event word carried through the edge buffer: {blank, strobe, data}
  localparam int EVT_W = 3;
  localparam int EVT_DATA = 0;
  localparam int EVT_STROBE = 1;
  localparam int EVT_BLANK = 2;
  // least evaluation time the host leaves blank low, in ns and cycles at 40 MHz
  localparam int EVAL_MIN_NS = 1000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int EVAL_MIN_CYC = (EVAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // power-on values
  localparam logic SHUTDOWN_RST = 1'b1;
  localparam logic [15:0] DATA_RST = 16'h0000;

  typedef enum logic [1:0] {LSSLD_IDLE, LSSLD_ARMED, LSSLD_EVAL, LSSLD_DONE} lssld_det_type;
endpackage

`default_nettype wire

// File: logic/lssld_buf.sv
/*
  Small FIFO with valid/ready on both sides; depth and width are
  parameters (depth a power of two). Assumes one clock and an
  asynchronous active-low reset shared with its user.
*/
`timescale 1ns/10ps
`default_nettype none

module lssld_buf #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // -----------------------------------------------------------------
  // flags and read port
  // -----------------------------------------------------------------
  // full only when every slot holds a word; count is one bit wider than the pointers
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];

  // storage; no reset needed since valid guards every read
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

  // pointers and occupancy
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + AW'(1);
      if (pop)
        rd_ptr_r <= rd_ptr_r + AW'(1);
      if (push && !pop)
        count_r <= count_r + (AW+1)'(1);
      else if (pop && !push)
        count_r <= count_r - (AW+1)'(1);
    end
  end
endmodule

`default_nettype wire

// File: logic/lssld_core.sv
/*
  Serial-in/parallel-out control for a 16-channel LED sink: shift
  register, level-sensitive latch, output blanking, auto shutdown,
  and the pin-pattern driven open/short detection mode.
  Assumes all pins (serial clock, data, strobe, blank, comparator
  flags) are asynchronous to clk_sys and slower than it by a wide
  margin; the serial clock is sampled, not used as a clock.
*/
`timescale 1ns/10ps
`default_nettype none

module lssld_core
#(
  parameter int CHANS = lssld_pkg::CHAN_NUM
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic latch_strobe_mode_ctl1,
  input wire logic output_blank_mode_ctl2,
  input wire logic [CHANS-1:0] detected_current_low,
  input wire logic [CHANS-1:0] output_voltage_high,
  output logic [CHANS-1:0] chan_on,
  output logic serial_out,
  output logic shutdown_state,
  output logic detect_mode,
  output logic edge_overrun
);
  import lssld_pkg::*;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic clk_s3_r;
  logic [2*CHANS-1:0] cmp_s1_r;
  logic [2*CHANS-1:0] cmp_s2_r;

  // first stage is read only by the second stage
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      clk_s3_r <= 1'b0;
      cmp_s1_r <= '0;
      cmp_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= {output_blank_mode_ctl2, latch_strobe_mode_ctl1, serial_in, serial_clk};
      pin_s2_r <= pin_s1_r;
      clk_s3_r <= pin_s2_r[0];
      cmp_s1_r <= {output_voltage_high, detected_current_low};
      cmp_s2_r <= cmp_s1_r;
    end
  end

  wire clk_rise = pin_s2_r[0] && !clk_s3_r;
  wire data_lvl = pin_s2_r[1];
  wire strobe_lvl = pin_s2_r[2];
  wire blank_lvl = pin_s2_r[3];
  wire [CHANS-1:0] cur_low = cmp_s2_r[CHANS-1:0];
  wire [CHANS-1:0] volt_high = cmp_s2_r[2*CHANS-1:CHANS];

  // -----------------------------------------------------------------
  // edge event buffer
  // -----------------------------------------------------------------
  // each serial clock rise is queued with its data/strobe/blank
  // sample, so a one-cycle stall for the result load drops no bit
  logic [EVT_W-1:0] evt_data;
  logic evt_valid;
  logic evt_ready;
  logic buf_in_ready;
  logic load_pend_r;
  wire [EVT_W-1:0] evt_in = {blank_lvl, strobe_lvl, data_lvl};

  assign evt_ready = !load_pend_r;

  lssld_buf #(
    .WIDTH(EVT_W),
    .DEPTH(2)
  ) u_evt_buf (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_data(evt_in),
    .in_valid(clk_rise),
    .in_ready(buf_in_ready),
    .out_data(evt_data),
    .out_valid(evt_valid),
    .out_ready(evt_ready)
  );

  wire evt_take = evt_valid && evt_ready;
  wire evt_sdi = evt_data[EVT_DATA];
  wire evt_strobe = evt_data[EVT_STROBE];
  wire evt_blank = evt_data[EVT_BLANK];

  // -----------------------------------------------------------------
  // mode-sequence recogniser
  // -----------------------------------------------------------------
  logic [2:0] seq_step_r;
  logic [2:0] seq_step_nxt;
  logic detect_r;
  logic detect_nxt;

  // expected strobe depends on direction: entry from normal, resume from detect
  wire [4:0] exp_strobe = detect_r ? SEQ_RESUME_STROBE : SEQ_ENTER_STROBE;
  wire step_hit = (evt_blank == SEQ_BLANK[seq_step_r])
               && (evt_strobe == exp_strobe[seq_step_r]);
  wire first_hit = (evt_blank == SEQ_BLANK[0]) && (evt_strobe == exp_strobe[0]);
  wire seq_done = step_hit && (seq_step_r == 3'(SEQ_LEN - 1));

  // a mismatch restarts, reusing the sample if it opens a new pattern
  assign seq_step_nxt = !evt_take ? seq_step_r :
                        seq_done ? 3'h0 :
                        step_hit ? seq_step_r + 3'h1 :
                        first_hit ? 3'h1 : 3'h0;
  // the mode flips on the fifth matched rise, so rise six is detect data
  assign detect_nxt = (evt_take && seq_done) ? !detect_r : detect_r;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seq_step_r <= 3'h0;
      detect_r <= 1'b0;
    end
    else
    begin
      seq_step_r <= seq_step_nxt;
      detect_r <= detect_nxt;
    end
  end

  // -----------------------------------------------------------------
  // detection sequencing
  // -----------------------------------------------------------------
  lssld_det_type det_r;
  lssld_det_type det_nxt;
  logic [CHANS-1:0] result_r;
  wire [CHANS-1:0] chan_good = ~(cur_low | volt_high);

  // one evaluation per stay in detect mode; leaving resets it
  always_comb
  begin
    det_nxt = det_r;
    case (det_r)
      LSSLD_IDLE:
        if (detect_r && blank_lvl)
          det_nxt = LSSLD_ARMED;
      LSSLD_ARMED:
        if (!blank_lvl)
          det_nxt = LSSLD_EVAL;
      LSSLD_EVAL:
        if (blank_lvl)
          det_nxt = LSSLD_DONE;
      LSSLD_DONE:
        det_nxt = LSSLD_DONE;
      default:
        det_nxt = LSSLD_IDLE;
    endcase
    if (!detect_r)
      det_nxt = LSSLD_IDLE;
  end

  wire det_finish = (det_r == LSSLD_EVAL) && blank_lvl && detect_r;

  // results track the comparators while blank is low in the evaluation state
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      det_r <= LSSLD_IDLE;
      result_r <= CHANS'(DATA_RST);
      load_pend_r <= 1'b0;
    end
    else
    begin
      det_r <= det_nxt;
      if (det_r == LSSLD_EVAL && !blank_lvl)
        result_r <= chan_good;
      load_pend_r <= det_finish;
    end
  end

  // -----------------------------------------------------------------
  // shift register, latch, outputs
  // -----------------------------------------------------------------
  logic [CHANS-1:0] shift_r;
  logic [CHANS-1:0] latch_r;
  wire [CHANS-1:0] shift_nxt = load_pend_r ? result_r :
                               evt_take ? {shift_r[CHANS-2:0], evt_sdi} : shift_r;
  // latch is transparent on strobe level, no edge involved
  wire [CHANS-1:0] latch_nxt = strobe_lvl ? shift_nxt : latch_r;
  wire all_zero = (latch_nxt == '0);
  // blank low drives latched data; shutdown implies all-zero data anyway
  wire [CHANS-1:0] chan_nxt = blank_lvl ? '0 : latch_nxt;

  // power-up state is shutdown with an empty latch
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_r <= CHANS'(DATA_RST);
      latch_r <= CHANS'(DATA_RST);
      chan_on <= '0;
      serial_out <= 1'b0;
      shutdown_state <= SHUTDOWN_RST;
      detect_mode <= 1'b0;
      edge_overrun <= 1'b0;
    end
    else
    begin
      shift_r <= shift_nxt;
      latch_r <= latch_nxt;
      chan_on <= chan_nxt;
      serial_out <= shift_nxt[CHANS-1];
      shutdown_state <= all_zero;
      detect_mode <= detect_nxt;
      edge_overrun <= clk_rise && !buf_in_ready;  // serial clock too fast for clk_sys
    end
  end
endmodule

`default_nettype wire

// File: test/lssld_core_monitor.sv
/* checker on lssld_core pins, bound below
   assumes host pins change just after a clk_sys rise */
`timescale 1ns/10ps
`default_nettype none
module lssld_core_monitor #(
  parameter int CHANS = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic serial_clk,
  input wire logic latch_strobe_mode_ctl1,
  input wire logic output_blank_mode_ctl2,
  input wire logic [CHANS-1:0] chan_on,
  input wire logic serial_out,
  input wire logic shutdown_state,
  input wire logic detect_mode
);
  // -------
  // checks, strobe and blank reach outputs three clocks late
  // -------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  property p_rst; $rose(reset_n) |-> shutdown_state && !detect_mode; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_blank; output_blank_mode_ctl2 [*4] |-> ~|chan_on; endproperty
  a_blank: assert property (p_blank) else $error("lit while blanked");
  property p_on; |chan_on |-> !$past(output_blank_mode_ctl2, 3); endproperty
  a_on: assert property (p_on) else $error("lit without enable");
  // both levels low for five samples: latch and drive must hold
  property p_hold;
    (!latch_strobe_mode_ctl1 && !output_blank_mode_ctl2) [*5] |-> $stable(chan_on);
  endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_shut; $changed(shutdown_state) |-> $past(latch_strobe_mode_ctl1, 3); endproperty
  a_shut: assert property (p_shut) else $error("sleep change w/o strobe");
  property p_dark; shutdown_state |-> ~|chan_on; endproperty
  a_dark: assert property (p_dark) else $error("lit in shutdown");
  // no serial clock rise for a while outside detect mode: nothing may shift
  property p_sout; (!serial_clk && !detect_mode) [*8] |-> $stable(serial_out); endproperty
  a_sout: assert property (p_sout) else $error("shift w/o clock");
  property p_mode; !serial_clk [*8] |-> $stable(detect_mode); endproperty
  a_mode: assert property (p_mode) else $error("mode w/o clock");
  c_wake: cover property ($fell(shutdown_state));
  c_enter: cover property ($rose(detect_mode));
  c_leave: cover property ($fell(detect_mode));
endmodule

bind lssld_core lssld_core_monitor #(.CHANS(CHANS)) mon (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .serial_clk(serial_clk),
  .latch_strobe_mode_ctl1(latch_strobe_mode_ctl1),
  .output_blank_mode_ctl2(output_blank_mode_ctl2),
  .chan_on(chan_on),
  .serial_out(serial_out),
  .shutdown_state(shutdown_state),
  .detect_mode(detect_mode)
);
`default_nettype wire

// File: test/lssld_host.sv
/* host model: serial clock, data, strobe, blank
   assumes clk_sys from the bench; pins move 2 ns after its rise */
`timescale 1ns/10ps
`default_nettype none
module lssld_host
  import lssld_pkg::*;
(
  input wire logic clk_sys,
  output logic serial_clk,
  output logic serial_in,
  output logic latch_strobe_mode_ctl1,
  output logic output_blank_mode_ctl2
);
  // idle: clock still, outputs blanked
  initial
  begin
    serial_clk = 1'b0;
    serial_in = 1'b0;
    latch_strobe_mode_ctl1 = 1'b0;
    output_blank_mode_ctl2 = 1'b1;
  end
  // step n rises, then move off the edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  // levels held four clocks so the sampler sees them
  task automatic pins(input logic stb, input logic bl);
    latch_strobe_mode_ctl1 = stb;
    output_blank_mode_ctl2 = bl;
    wait_clk(4);
  endtask
  // one bit, slow enough for two-flop sampling of the clock
  task automatic send(input logic d, input logic stb, input logic bl);
    serial_in = d;
    pins(stb, bl);
    serial_clk = 1'b1;
    wait_clk(4);
    serial_clk = 1'b0;
    wait_clk(2);
  endtask
  // msb first, so the first bit lands in channel 15
  task automatic word(input logic [15:0] v, input logic stb, input logic bl);
    for (int i = 15; i >= 0; i--)
      send(v[i], stb, bl);
  endtask
  // first n steps of the entry or resume pattern
  task automatic pattern(input logic enter, input int n);
    logic [4:0] s;
    s = enter ? SEQ_ENTER_STROBE : SEQ_RESUME_STROBE;
    for (int i = 0; i < n; i++)
      send(1'b0, s[i], SEQ_BLANK[i]);
  endtask
endmodule
`default_nettype wire

// File: test/lssld_core_tb.sv
/* self-checking bench for lssld_core
   assumes lssld_host drives every pin off the clk_sys rise */
`timescale 1ns/10ps
`default_nettype none
module lssld_core_tb;
  import lssld_pkg::*;
  logic clk_sys;
  logic reset_n;
  logic sck, sin, stb, bl, sout, shut, dmode, ovr;
  int ovr_seen = 0;
  logic [15:0] cur_low, volt_high, chan_on;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  lssld_host host (
    .clk_sys(clk_sys),
    .serial_clk(sck),
    .serial_in(sin),
    .latch_strobe_mode_ctl1(stb),
    .output_blank_mode_ctl2(bl)
  );
  lssld_core dut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .serial_clk(sck),
    .serial_in(sin),
    .latch_strobe_mode_ctl1(stb),
    .output_blank_mode_ctl2(bl),
    .detected_current_low(cur_low),
    .output_voltage_high(volt_high),
    .chan_on(chan_on),
    .serial_out(sout),
    .shutdown_state(shut),
    .detect_mode(dmode),
    .edge_overrun(ovr)
  );
  // -------
  // clock, guard, compare, verdict
  // -------
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // hang guard, run needs about a thousand cycles
  // also counts lost serial clock rises, which a slow host must never cause
  always @(posedge clk_sys)
  begin
    cyc++;
    if (ovr === 1'b1)
      ovr_seen++;
    if (cyc == 4000)
    begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // shift with strobe low, latch, blank, unblank, clear
  task automatic t_latch;
    host.word(16'hA5C3, 1'b0, 1'b0);
    chk(chan_on, 16'h0000);
    chk({15'h0000, sout}, 16'h0001);
    host.pins(1'b1, 1'b0);
    chk(chan_on, 16'hA5C3);
    chk({15'h0000, shut}, 16'h0000);
    host.pins(1'b0, 1'b1);
    chk(chan_on, 16'h0000);
    host.pins(1'b0, 1'b0);
    chk(chan_on, 16'hA5C3);
    host.word(16'h0000, 1'b1, 1'b0);
    chk({15'h0000, shut}, 16'h0001);
  endtask
  // enter, evaluate, read back, no rerun, resume
  task automatic t_detect;
    logic [15:0] res;
    cur_low = 16'h0010;
    volt_high = 16'h8001;
    host.pattern(1'b1, 5);
    chk({15'h0000, dmode}, 16'h0001);
    host.word(16'hFFFF, 1'b0, 1'b1);
    host.pins(1'b1, 1'b1);
    host.pins(1'b0, 1'b0);
    chk(chan_on, 16'hFFFF);
    host.wait_clk(EVAL_MIN_CYC);
    host.pins(1'b0, 1'b1);
    host.wait_clk(2);
    res = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      if (i > 0)
        host.send(1'b0, 1'b0, 1'b1);
      res = {res[14:0], sout};
    end
    chk(res, 16'h7FEE);
    cur_low = 16'h0000;
    volt_high = 16'h0000;
    host.pins(1'b0, 1'b0);
    host.wait_clk(EVAL_MIN_CYC);
    host.pins(1'b0, 1'b1);
    host.wait_clk(2);
    chk({15'h0000, sout}, 16'h0000);
    host.pattern(1'b0, 5);
    chk({15'h0000, dmode}, 16'h0000);
  endtask
  // power-up state right after reset
  task automatic t_reset;
    chk(chan_on, 16'h0000);
    chk({14'h0000, shut, dmode}, 16'h0002);
  endtask
  // broken entry pattern must leave the mode alone
  task automatic t_restart;
    host.pattern(1'b1, 4);
    host.send(1'b0, 1'b0, 1'b0);
    chk({15'h0000, dmode}, 16'h0000);
  endtask
  initial
  begin
    reset_n = 1'b0;
    cur_low = 16'h0000;
    volt_high = 16'h0000;
    repeat (5) @(posedge clk_sys);
    #2;
    reset_n = 1'b1;
    host.wait_clk(2);
    t_reset();
    t_latch();
    t_restart();
    t_detect();
    chk(ovr_seen[15:0], 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
